// File: design/ard_pkg.sv
// Package of constants for the alarm relay driver
package ard_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned RELAY_COUNT = 3;
  localparam int unsigned SRC_W = 2;

  // ****************************************
  // Alarm source encodings
  // ****************************************
  localparam logic [1:0] SRC_ALARM = 2'h0;
  localparam logic [1:0] SRC_WARNING = 2'h1;
  localparam logic [1:0] SRC_CAUTION = 2'h2;
  localparam logic [1:0] SRC_TROUBLE = 2'h3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELAY0 = 8'h04;
  localparam logic [7:0] OFS_RELAY1 = 8'h08;
  localparam logic [7:0] OFS_RELAY2 = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned RELAY_SRC_LSB = 0;
  localparam int unsigned RELAY_NORM_BIT = 4;
  localparam int unsigned STATUS_COIL_LSB = 0;
  localparam int unsigned STATUS_ALM_LSB = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_ENABLE = 1'h0;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic RST_NORM = 1'h0;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: design/ard_relay_driver.sv
// Alarm relay driver with AXI4-Lite register access
`timescale 1ns/10ps

// Notes on behaviour
// - Three relays, each own source and norm
// - Each coil follows one of four sources
// - Norm zero: energize only while alarm active
// - Norm one: energized until alarm goes active
// - Fail-safe: de-energized means alarm, power loss or enable cleared
// - One enable switches all relays together
module ard_relay_driver
  import ard_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Alarm levels from device logic
  input wire logic alarm_lvl,
  input wire logic warning_lvl,
  input wire logic caution_lvl,
  input wire logic trouble_lvl,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Relay coil drives, high energizes
  output logic [RELAY_COUNT-1:0] coil_q
);

  // ****************************************
  // Configuration and state
  // ****************************************
  logic enable_q;
  logic [SRC_W-1:0] src_q [RELAY_COUNT];
  logic [RELAY_COUNT-1:0] norm_q;
  logic [3:0] alm_q;
  logic [3:0] coil_d_alm;
  logic [RELAY_COUNT-1:0] coil_d;

  // Alarm inputs come from device logic on this clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alm_q <= 4'h0;
    end else begin
      alm_q <= {trouble_lvl, caution_lvl, warning_lvl, alarm_lvl};
    end
  end

  assign coil_d_alm = alm_q;

  // ****************************************
  // Coil logic
  // ****************************************
  function automatic logic pick_src(input logic [3:0] alm, input logic [1:0] sel);
    logic r;
    r = 1'b0;
    case (sel)
      SRC_ALARM: r = alm[0];
      SRC_WARNING: r = alm[1];
      SRC_CAUTION: r = alm[2];
      SRC_TROUBLE: r = alm[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < RELAY_COUNT; i++) begin
      // Norm 0 energizes on alarm, norm 1 drops out on alarm
      coil_d[i] = enable_q & (pick_src(coil_d_alm, src_q[i]) ^ norm_q[i]);
    end
  end

  // Reset leaves coils off, same as power loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_q <= '0;
    end else begin
      coil_q <= coil_d;
    end
  end

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic wr_hit;

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_RELAY0) || (awaddr_q == OFS_RELAY1) ||
                  (awaddr_q == OFS_RELAY2) || (awaddr_q == OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= RST_ENABLE;
    end else if (wr_go && awaddr_q == OFS_CTRL && wstrb_q[0]) begin
      enable_q <= wdata_q[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < RELAY_COUNT; i++) begin
        src_q[i] <= RST_SRC;
        norm_q[i] <= RST_NORM;
      end
    end else if (wr_go && wstrb_q[0]) begin
      for (int i = 0; i < RELAY_COUNT; i++) begin
        if (awaddr_q == OFS_RELAY0 + 8'(4 * i)) begin
          src_q[i] <= wdata_q[RELAY_SRC_LSB +: SRC_W];
          norm_q[i] <= wdata_q[RELAY_NORM_BIT];
        end
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      OFS_CTRL: v[CTRL_ENABLE_BIT] = enable_q;
      OFS_RELAY0: v = {27'h0, norm_q[0], 2'h0, src_q[0]};
      OFS_RELAY1: v = {27'h0, norm_q[1], 2'h0, src_q[1]};
      OFS_RELAY2: v = {27'h0, norm_q[2], 2'h0, src_q[2]};
      OFS_STATUS: begin
        v[STATUS_COIL_LSB +: RELAY_COUNT] = coil_q;
        v[STATUS_ALM_LSB +: 4] = alm_q;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic rd_hit(input logic [7:0] addr);
    return (addr == OFS_CTRL) || (addr == OFS_RELAY0) || (addr == OFS_RELAY1) ||
           (addr == OFS_RELAY2) || (addr == OFS_STATUS);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word(s_axi_araddr);
      s_axi_rresp <= rd_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: tb/ard_relay_driver_sva.sv
// Port checker for the alarm relay driver
`timescale 1ns/10ps
module ard_chk import ard_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Alarm levels
  input wire logic alarm_lvl,
  input wire logic warning_lvl,
  input wire logic caution_lvl,
  input wire logic trouble_lvl,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Coil drives
  input wire logic [RELAY_COUNT-1:0] coil_q
);
  // ****************************************
  // Assertions
  // ****************************************
  wire logic [3:0] lv = {trouble_lvl, caution_lvl, warning_lvl, alarm_lvl};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A coil moves only two edges after a level change, after a setting write, or around reset
  coil_cause_a: assert property ($changed(coil_q) |-> $past(lv, 2) != $past(lv, 3) ||
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || !$past(aresetn) || !$past(aresetn, 3))
    else $error("coil moved without cause");
  rst_off_a: assert property (disable iff (1'b0) !aresetn |=> coil_q == '0) else $error("coil on in reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken twice");
  r_rise_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data unasked");
  cover property ($rose(coil_q[0]));
  cover property ($fell(coil_q[2]));
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind ard_relay_driver ard_chk i_chk (.*);

// File: tb/ard_relay_model.sv
// Model of the three mechanical relays behind the coil drives
`timescale 1ns/10ps
module ard_relay_model import ard_pkg::*; (
  // Clock
  input wire logic aclk,
  // Coils in, contact state out
  input wire logic [RELAY_COUNT-1:0] coil,
  output logic [RELAY_COUNT-1:0] no_closed
);
  // ****************************************
  // Armature
  // ****************************************
  // Unpowered coil rests on the C-NC side, as on power loss
  always_ff @(posedge aclk) begin
    no_closed <= coil;
  end
endmodule

// File: tb/tb.sv
// Testbench of the alarm relay driver
`timescale 1ns/10ps
module tb import ard_pkg::*; ;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] lv = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [2:0] coil_q, no_closed;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] d;
  logic [1:0] r;
  always #10 aclk = ~aclk;
  ard_relay_driver i_ard_relay_driver (.alarm_lvl(lv[0]), .warning_lvl(lv[1]), .caution_lvl(lv[2]),
    .trouble_lvl(lv[3]), .*);
  ard_relay_model i_ard_relay_model (.aclk(aclk), .coil(coil_q), .no_closed(no_closed));
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      s_axi_bready <= !s_axi_awvalid && !s_axi_wvalid && !(s_axi_bvalid && s_axi_bready);
    end while (!(s_axi_bvalid && s_axi_bready));
    chk(s_axi_bresp === e, "write response");
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      s_axi_rready <= !s_axi_arvalid && !(s_axi_rvalid && s_axi_rready);
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic t_codes;
    int k;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      for (int n = 0; n < 2; n++) begin
        k = s % 3;
        wr(OFS_RELAY0 + 8'(4 * k), 32'(n * 16 + s), RESP_OKAY);
        for (int b = 0; b < 4; b++) begin
          lv <= 4'h1 << b;
          repeat (4) @(posedge aclk);
          chk(coil_q[k] === ((b == s) ^ (n == 1)), "coil against source");
        end
      end
    end
    $display("test codes done");
  endtask
  task automatic t_disable;
    lv <= 4'h0;
    repeat (4) @(posedge aclk);
    chk(coil_q === 3'h7, "fail-safe rest");
    chk(no_closed === 3'h7, "contacts at rest");
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(coil_q === 3'h0, "disabled fail-safe coils");
    lv <= 4'hF;
    repeat (4) @(posedge aclk);
    chk(coil_q === 3'h0, "disabled coils");
    $display("test disable done");
  endtask
  task automatic t_regs;
    rd(OFS_RELAY0);
    chk(d === 32'h13 && r === RESP_OKAY, "relay setting readback");
    wr(8'h14, 32'h1, RESP_SLVERR);
    rd(8'h14);
    chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
    rd(OFS_CTRL);
    chk(d === 32'h0 && r === RESP_OKAY, "enable readback");
    rd(OFS_STATUS);
    chk(d === 32'h0000_0F00 && r === RESP_OKAY, "status readback");
    $display("test regs done");
  endtask
  task automatic t_reset;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    lv <= 4'h0;
    repeat (4) @(posedge aclk);
    chk(coil_q === 3'h7, "fail-safe after re-enable");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk(coil_q === 3'h0, "coils off in reset");
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(OFS_RELAY0);
    chk(d === 32'h0, "relay setting reset");
    rd(OFS_CTRL);
    chk(d === 32'h0, "enable reset");
    $display("test reset done");
  endtask
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      close_out;
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_codes;
    t_disable;
    t_regs;
    t_reset;
    close_out;
  end
endmodule
